// ### rosel_pkg.sv
package rosel_pkg;

  // Bus and map geometry.
  localparam int           ADDR_W     = 12;
  localparam int           NUM_REGS   = 6;
  localparam int           NUM_PINS   = 12;
  localparam int           NUM_FUNC   = 32;
  localparam int           FIELD_W    = 5;

  // Register byte offsets, one aligned word each.
  localparam logic [11:0]  OFF_PINS_12_13 = 12'h000;
  localparam logic [11:0]  OFF_PINS_14_15 = 12'h004;
  localparam logic [11:0]  OFF_PINS_16_17 = 12'h008;
  localparam logic [11:0]  OFF_PINS_18_19 = 12'h00C;
  localparam logic [11:0]  OFF_PINS_20_21 = 12'h010;
  localparam logic [11:0]  OFF_PINS_22_23 = 12'h014;

  // Field positions inside each selection register.
  localparam int           EVEN_LSB   = 0;
  localparam int           ODD_LSB    = 8;

  // Reset value of a selection field; zero also means no peripheral.
  localparam logic [4:0]   SEL_NONE   = 5'h00;

  // Pin index of the first field that exists only on the large package.
  localparam logic [3:0]   LARGE_FIRST_PIN = 4'h4;

  // Reset value of the bus read data.
  localparam logic [31:0]  RDATA_RST  = 32'h0000_0000;

endpackage

// ### rosel_sel_if.sv
`timescale 1ns/100ps
interface rosel_sel_if;
  import rosel_pkg::*;

  // Per-pin function selects, peripheral outputs and port data.
  logic [FIELD_W-1:0]  func_sel [NUM_PINS];
  logic [NUM_FUNC-1:0] periph_out;
  logic [NUM_PINS-1:0] port_out;
  logic [NUM_PINS-1:0] pin_out;
  logic [NUM_PINS-1:0] pin_owned;

  modport ctrl (
    output func_sel,
    output periph_out,
    output port_out,
    input  pin_out,
    input  pin_owned
  );

  modport mux (
    input  func_sel,
    input  periph_out,
    input  port_out,
    output pin_out,
    output pin_owned
  );

endinterface

// ### rosel_pin_mux.sv
`timescale 1ns/100ps
module rosel_pin_mux
  import rosel_pkg::*;
(
  // Select bus from the register file.
  rosel_sel_if.mux sel_bus
);

  // Picks the numbered peripheral output, or the port bit for select zero.
  function automatic logic route_bit(input logic [FIELD_W-1:0]  sel,
                                     input logic [NUM_FUNC-1:0] funcs,
                                     input logic                port_bit);
    route_bit = (sel == SEL_NONE) ? port_bit : funcs[sel];
  endfunction

  // Each remappable pin gets its own selector.
  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      sel_bus.pin_out[p]   = route_bit(sel_bus.func_sel[p],
                                       sel_bus.periph_out,
                                       sel_bus.port_out[p]);
      sel_bus.pin_owned[p] = (sel_bus.func_sel[p] != SEL_NONE);
    end
  end

endmodule

// ### rosel_top.sv
`timescale 1ns/100ps
// Functional notes
// - Bits 15:13 and 7:5 of each register ignore writes and read zero.
// - Bits 12:8 select the function of odd pin 13, 15, 17, 19, 21 or 23.
// - Bits 4:0 select the function of even pin 12, 14, 16, 18, 20 or 22.
// - Every implemented selection field is zero after power-on reset.
// - Pin 16 to 23 fields exist only on the large package, else read zero.
module rosel_top
  import rosel_pkg::*;
#(
  parameter bit LARGE_PKG = 1'b1
) (
  // Clock and reset.
  input  wire logic                I_CLK,
  input  wire logic                I_ARST_N,
  // APB slave.
  input  wire logic                I_PSEL,
  input  wire logic                I_PENABLE,
  input  wire logic                I_PWRITE,
  input  wire logic [ADDR_W-1:0]   I_PADDR,
  input  wire logic [31:0]         I_PWDATA,
  input  wire logic [3:0]          I_PSTRB,
  output logic      [31:0]         O_PRDATA,
  output logic                     O_PREADY,
  output logic                     O_PSLVERR,
  // Peripheral outputs, function number is the bit index, bit 0 unused.
  input  wire logic [NUM_FUNC-1:0] I_PERIPH_OUT,
  // Ordinary port data for pins 12 to 23.
  input  wire logic [NUM_PINS-1:0] I_PORT_OUT,
  // Remappable pins 12 to 23.
  output logic      [NUM_PINS-1:0] O_PIN_OUT,
  output logic      [NUM_PINS-1:0] O_PIN_OWNED
);

  rosel_sel_if sel_bus ();

  logic [FIELD_W-1:0]  sel_q [NUM_PINS];
  logic [FIELD_W-1:0]  sel_d [NUM_PINS];
  logic [31:0]         prdata_q, prdata_d;
  logic                pready_q, pready_d;
  logic                pslverr_q, pslverr_d;
  logic [NUM_PINS-1:0] pin_out_q, pin_out_d;
  logic [NUM_PINS-1:0] owned_q, owned_d;
  logic                hit;
  logic [2:0]          idx;
  logic [3:0]          dec;
  logic [3:0]          even_pin, odd_pin;
  logic                wr_acc;
  logic                setup;

  // Maps a byte address onto a register index.
  function automatic logic [3:0] decode(input logic [ADDR_W-1:0] addr);
    case (addr)
      OFF_PINS_12_13: decode = 4'h8;
      OFF_PINS_14_15: decode = 4'h9;
      OFF_PINS_16_17: decode = 4'hA;
      OFF_PINS_18_19: decode = 4'hB;
      OFF_PINS_20_21: decode = 4'hC;
      OFF_PINS_22_23: decode = 4'hD;
      default:        decode = 4'h0;
    endcase
  endfunction

  // True when a pin's field exists on this package.
  function automatic logic field_impl(input logic [3:0] pin);
    field_impl = LARGE_PKG || (pin < LARGE_FIRST_PIN);
  endfunction

  // Address decode and phase qualifiers.
  assign dec      = decode(I_PADDR);
  assign hit      = dec[3];
  assign idx      = dec[2:0];
  assign even_pin = {idx, 1'b0};
  assign odd_pin  = {idx, 1'b1};
  assign setup    = I_PSEL && !I_PENABLE;
  assign wr_acc   = I_PSEL && I_PENABLE && pready_q && I_PWRITE && hit;

  // Connect the register file to the pin selectors.
  assign sel_bus.func_sel   = sel_q;
  assign sel_bus.periph_out = I_PERIPH_OUT;
  assign sel_bus.port_out   = I_PORT_OUT;

  rosel_pin_mux u_mux (
    .sel_bus (sel_bus.mux)
  );

  // Next values of fields, bus answer and pin outputs.
  always_comb begin
    sel_d = sel_q;
    if (wr_acc) begin
      if (I_PSTRB[0] && field_impl(even_pin)) begin
        sel_d[even_pin] = I_PWDATA[EVEN_LSB +: FIELD_W];
      end
      if (I_PSTRB[1] && field_impl(odd_pin)) begin
        sel_d[odd_pin] = I_PWDATA[ODD_LSB +: FIELD_W];
      end
    end
    pready_d  = setup;
    pslverr_d = setup && !hit;
    prdata_d  = RDATA_RST;
    if (setup && !I_PWRITE && hit) begin
      prdata_d = {16'h0000, 3'h0, sel_q[odd_pin],
                  3'h0, sel_q[even_pin]};
    end
    pin_out_d = sel_bus.pin_out;
    owned_d   = sel_bus.pin_owned;
  end

  // State registers.
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      for (int p = 0; p < NUM_PINS; p++) begin
        sel_q[p] <= SEL_NONE;
      end
      prdata_q  <= RDATA_RST;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      pin_out_q <= '0;
      owned_q   <= '0;
    end else begin
      sel_q     <= sel_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      pin_out_q <= pin_out_d;
      owned_q   <= owned_d;
    end
  end

  // Outputs straight from flip-flops.
  assign O_PRDATA    = prdata_q;
  assign O_PREADY    = pready_q;
  assign O_PSLVERR   = pslverr_q;
  assign O_PIN_OUT   = pin_out_q;
  assign O_PIN_OWNED = owned_q;

  // Helper state for the checks below.
  logic                rst_seen_q;
  logic [FIELD_W-1:0]  wr_even_val, wr_odd_val;
  logic [FIELD_W*8-1:0] large_sels;

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rst_seen_q <= 1'b0;
    end else begin
      rst_seen_q <= 1'b1;
    end
  end

  assign wr_even_val = I_PWDATA[EVEN_LSB +: FIELD_W];
  assign wr_odd_val  = I_PWDATA[ODD_LSB +: FIELD_W];
  assign large_sels  = {sel_q[11], sel_q[10], sel_q[9], sel_q[8],
                        sel_q[7], sel_q[6], sel_q[5], sel_q[4]};

  sequence s_setup;
    I_PSEL && !I_PENABLE;
  endsequence

  sequence s_write_done;
    I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && hit;
  endsequence

  sequence s_read_done;
    I_PSEL && I_PENABLE && O_PREADY && !I_PWRITE && hit;
  endsequence

  // A setup cycle is answered in the very next cycle.
  apb_answer_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    s_setup |=> O_PREADY)
    else $error("Setup phase was not answered one cycle later.");

  unimpl_bits_zero_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    s_read_done |-> (O_PRDATA[31:13] == 19'h0_0000) && (O_PRDATA[7:5] == 3'h0))
    else $error("Unimplemented bits read back nonzero.");

  odd_field_write_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (s_write_done and I_PSTRB[1] && field_impl(odd_pin))
      |=> sel_q[$past(odd_pin)] == $past(wr_odd_val))
    else $error("Odd pin select did not take the written value.");

  even_field_write_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (s_write_done and I_PSTRB[0] && field_impl(even_pin))
      |=> sel_q[$past(even_pin)] == $past(wr_even_val))
    else $error("Even pin select did not take the written value.");

  large_write_drop_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (s_write_done and I_PSTRB[0] && !field_impl(even_pin))
      |=> sel_q[$past(even_pin)] == SEL_NONE)
    else $error("Even select of a missing pin took a write.");

  reset_sel_zero_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    !rst_seen_q |-> ({sel_q[3], sel_q[2], sel_q[1], sel_q[0]} == '0) &&
      (large_sels == '0) && (O_PIN_OWNED == '0))
    else $error("Selection fields not zero after reset.");

  small_pkg_zero_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    LARGE_PKG || (large_sels == '0))
    else $error("Large package field set on small package.");

  read_data_match_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    s_setup ##1 s_read_done |->
      O_PRDATA[12:8] == sel_q[odd_pin] && O_PRDATA[4:0] == sel_q[even_pin])
    else $error("Read data does not match stored selects.");

  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin_chk
    pin_route_a: assert property (
      @(posedge I_CLK) disable iff (!I_ARST_N)
      rst_seen_q && (sel_q[g] != SEL_NONE) |=>
        O_PIN_OWNED[g] && O_PIN_OUT[g] == $past(I_PERIPH_OUT[sel_q[g]]))
      else $error("Pin not driven by its selected function.");

    pin_release_a: assert property (
      @(posedge I_CLK) disable iff (!I_ARST_N)
      rst_seen_q && (sel_q[g] == SEL_NONE) |=>
        !O_PIN_OWNED[g] && O_PIN_OUT[g] == $past(I_PORT_OUT[g]))
      else $error("Unselected pin not left to port logic.");
  end

endmodule

// ### rosel_periph_model.sv
`timescale 1ns/100ps
module rosel_periph_model
  import rosel_pkg::*;
(
  // Clock.
  input  wire logic                i_clk,
  // Peripheral outputs and port data toward the selector.
  output logic      [NUM_FUNC-1:0] o_periph,
  output logic      [NUM_PINS-1:0] o_port
);
  int seed = 52;

  // Start from known levels.
  initial begin
    o_periph = '0;
    o_port   = '0;
  end

  // New values each cycle, so a stale or wrong route cannot pass by luck.
  always @(posedge i_clk) begin
    o_periph <= 32'($random(seed)) & 32'hFFFF_FFFE;
    o_port   <= 12'($random(seed));
  end
endmodule

// ### rosel_top_test.sv
`timescale 1ns/100ps
module rosel_top_test;
  import rosel_pkg::*;
  logic                I_CLK;
  logic                I_ARST_N;
  logic                I_PSEL;
  logic                I_PENABLE;
  logic                I_PWRITE;
  logic [ADDR_W-1:0]   I_PADDR;
  logic [31:0]         I_PWDATA;
  logic [3:0]          I_PSTRB;
  logic [31:0]         O_PRDATA;
  logic [31:0]         s_prdata;
  logic                O_PREADY;
  logic                O_PSLVERR;
  logic [NUM_FUNC-1:0] periph;
  logic [NUM_PINS-1:0] port;
  logic [NUM_PINS-1:0] O_PIN_OUT;
  logic [NUM_PINS-1:0] O_PIN_OWNED;
  logic [15:0]         sh [NUM_REGS];
  logic [64:0]         rd_q [$];
  logic [23:0]         pin_q [$];
  int                  errors = 0;
  int                  n_tests = 0;
  int                  seed = 52;
  logic [31:0]         rnd_d;
  logic [3:0]          rnd_s;

  // Large and small package variants share one bus.
  rosel_top u_dut (.I_CLK, .I_ARST_N, .I_PSEL, .I_PENABLE, .I_PWRITE,
    .I_PADDR, .I_PWDATA, .I_PSTRB, .O_PRDATA, .O_PREADY, .O_PSLVERR,
    .I_PERIPH_OUT(periph), .I_PORT_OUT(port), .O_PIN_OUT, .O_PIN_OWNED);
  rosel_top #(.LARGE_PKG(1'b0)) u_dut_small (.I_CLK, .I_ARST_N, .I_PSEL,
    .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA, .I_PSTRB,
    .O_PRDATA(s_prdata), .O_PREADY(), .O_PSLVERR(),
    .I_PERIPH_OUT(periph), .I_PORT_OUT(port), .O_PIN_OUT(),
    .O_PIN_OWNED());
  rosel_periph_model u_model (.i_clk(I_CLK), .o_periph(periph),
    .o_port(port));

  // Clock of 10 ns period.
  initial begin
    I_CLK = 1'b0;
    forever #5 I_CLK = ~I_CLK;
  end

  // Compares one bus answer and counts it.
  task automatic cmp_bus(input logic [64:0] got, input logic [64:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Compares one pin state and counts it.
  task automatic cmp_pin(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One transfer; the shadow copy tracks what each register must hold.
  task automatic apb(input logic [ADDR_W-1:0] a, input logic wr,
                     input logic [31:0] d, input logic [3:0] s);
    int          i;
    logic [15:0] m;
    logic [64:0] e;
    i = int'(a) / 4;
    e = {1'b1, 64'h0};
    if (a[1:0] == 2'b00 && i < NUM_REGS) begin
      m = {3'h0, {5{s[1]}}, 3'h0, {5{s[0]}}};
      if (wr) sh[i] = (sh[i] & ~m) | (d[15:0] & m);
      e = wr ? 65'h0 : {1'b0, 16'h0, sh[i], 16'h0, i < 2 ? sh[i] : 16'h0};
    end
    rd_q.push_back(e);
    I_PSEL    <= 1'b1;
    I_PENABLE <= 1'b0;
    I_PWRITE  <= wr;
    I_PADDR   <= a;
    I_PWDATA  <= d;
    I_PSTRB   <= s;
    @(posedge I_CLK);
    I_PENABLE <= 1'b1;
    do @(posedge I_CLK); while (O_PREADY !== 1'b1);
  endtask

  // Releases the bus for one cycle.
  task automatic idle();
    I_PSEL    <= 1'b0;
    I_PENABLE <= 1'b0;
    @(posedge I_CLK);
  endtask

  // Notes the expected pin state for n cycles once selects have settled.
  task automatic pins(input int n);
    logic [4:0]  f;
    logic [23:0] e;
    repeat (3) @(posedge I_CLK);
    repeat (n) begin
      @(negedge I_CLK);
      for (int p = 0; p < NUM_PINS; p++) begin
        f = p[0] ? sh[p/2][12:8] : sh[p/2][4:0];
        e[p] = f == 5'h00 ? port[p] : periph[f];
        e[p+12] = f != 5'h00;
      end
      pin_q.push_back(e);
    end
    // The last note is compared just after the next edge; wait past it.
    repeat (2) @(posedge I_CLK);
  endtask

  // Bus answers are checked in the cycle they stand.
  always @(negedge I_CLK) begin
    if (O_PREADY === 1'b1 && rd_q.size() > 0) begin
      cmp_bus({O_PSLVERR, O_PRDATA, s_prdata}, rd_q.pop_front());
    end
  end

  // Pin outputs are checked just after each edge.
  always @(posedge I_CLK) begin
    #1;
    if (pin_q.size() > 0) begin
      cmp_pin({O_PIN_OWNED, O_PIN_OUT}, pin_q.pop_front());
    end
  end

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    // A note that was never matched by a result is a mismatch too.
    if (rd_q.size() != 0 || pin_q.size() != 0) begin
      errors++;
    end
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Cuts a hang short; the tests need well under 1000 cycles.
  initial begin
    #20000;
    errors++;
    conclude();
  end

  // Main sequence.
  initial begin
    I_ARST_N  = 1'b0;
    I_PSEL    = 1'b0;
    I_PENABLE = 1'b0;
    I_PWRITE  = 1'b0;
    I_PADDR   = '0;
    I_PWDATA  = '0;
    I_PSTRB   = '0;
    for (int i = 0; i < NUM_REGS; i++) sh[i] = 16'h0000;
    repeat (2) @(posedge I_CLK);
    I_ARST_N <= 1'b1;
    for (int i = 0; i < NUM_REGS; i++) begin
      apb(12'(i*4), 1'b0, 32'h0, 4'h0);
    end
    apb(12'h018, 1'b0, 32'h0000_0000, 4'h0);
    apb(12'h002, 1'b1, 32'hFFFF_FFFF, 4'hF);
    idle();
    pins(4);
    $display("reset test done");
    repeat (4) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        rnd_d = $random(seed);
        rnd_s = 4'($random(seed));
        apb(12'(i*4), 1'b1, rnd_d, rnd_s);
      end
      apb(12'h000, 1'b1, 32'hFFFF_E0E0, 4'hF);
      for (int i = 0; i < NUM_REGS; i++) begin
        apb(12'(i*4), 1'b0, 32'h0, 4'h0);
      end
      idle();
      pins(8);
    end
    $display("random test done");
    // Reset in mid-run with fields set: every field must fall back to zero.
    I_ARST_N <= 1'b0;
    for (int i = 0; i < NUM_REGS; i++) sh[i] = 16'h0000;
    repeat (2) @(posedge I_CLK);
    I_ARST_N <= 1'b1;
    for (int i = 0; i < NUM_REGS; i++) begin
      apb(12'(i*4), 1'b0, 32'h0, 4'h0);
    end
    idle();
    pins(4);
    $display("mid-run reset test done");
    conclude();
  end
endmodule
